// ==== hw/sfcmd_pkg.sv ====
// Package with opcodes, status layout, timing and state types for the flash command block
// Operation
// - Write enable opcode sets the write enable latch.
// - Volatile write enable leaves the latch alone, only arms a volatile status write.
// - Write disable opcode alone in a frame clears the write enable latch.
// - Latch clears at power-up, non-volatile status write end, program/erase end and reset.
// - Read-status opcodes shift the chosen status byte out MSB first on falling edges.
// - Read-status is accepted at any time, even while busy.
// - Status byte repeats until chip select rises.
// - Status writes change only writable bits of each register.
// - Lock bits and status lock hold at 1 through writes to their own copy; reset or a non-volatile write end reloads them.
// - Non-volatile status write needs the write enable latch set.
// - Volatile status write succeeds with the latch still at 0.
// - Reset discards volatile status and reloads the non-volatile copy.
// - Non-volatile write runs a timed busy cycle, then clears busy and latch.
// - Volatile write applies at once with busy kept at 0.
// - Register-1 write with 16 data bits writes registers 1 and 2, with 8 only 1.
// - Enter/exit opcodes alone switch between 32-bit and 24-bit addressing.
// - Read opcode takes 24/32-bit address on rising edges, data out on falling edges.
// - Read address advances after each byte until chip select rises.
// - Reads issued while busy are ignored.
// - Four-byte read opcode always takes a 32-bit address.
// - Plain and four-byte reads only work in single-wire standard mode.
// - Fast read inserts eight ignored dummy clocks before data.
package sfcmd_pkg;
  // Opcodes
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_VWREN = 8'h50;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_RDSR3 = 8'h15;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_WRSR3 = 8'h11;
  localparam logic [7:0] OP_EN4B = 8'hB7;
  localparam logic [7:0] OP_EX4B = 8'hE9;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ4 = 8'h13;
  localparam logic [7:0] OP_FAST = 8'h0B;
  // Frame bit counts (opcode, one data byte, two data bytes)
  localparam logic [6:0] BITS_OP = 7'h08;
  localparam logic [6:0] BITS_ONE = 7'h10;
  localparam logic [6:0] BITS_TWO = 7'h18;
  localparam logic [6:0] ADDR_END3 = 7'h20;
  localparam logic [6:0] ADDR_END4 = 7'h28;
  localparam logic [6:0] DUMMY_BITS = 7'h08;
  // Status bit positions
  localparam int BUSY_POS = 0;
  localparam int WEL_POS = 1;
  localparam int ADS_POS = 0;
  localparam int ADP_POS = 1;
  // Writable and one-time masks
  localparam logic [7:0] SR1_WMASK = 8'h7C;
  localparam logic [7:0] SR2_WMASK = 8'h7B;
  localparam logic [7:0] SR3_WMASK = 8'h66;
  localparam logic [7:0] SR2_OTP = 8'h39;
  // Non-volatile values after power-up
  localparam logic [7:0] SR1_RST = 8'h00;
  localparam logic [7:0] SR2_RST = 8'h00;
  localparam logic [7:0] SR3_RST = 8'h00;
  // Self-timed status write time and its cycle count at 10 MHz
  localparam int TW_NS = 100000;
  localparam int CLK_NS = 100;
  localparam logic [9:0] TW_CYC = 10'((TW_NS + CLK_NS - 1) / CLK_NS);

  // Link rising-edge state, cleared while chip select is high
  typedef struct packed {
    logic [6:0] bits;
    logic [7:0] sh;
    logic [31:0] addr;
    logic [6:0] addr_end;
    logic [6:0] data_start;
    logic is_read;
    logic is_stat;
    logic [1:0] stat_sel;
    logic stream;
    logic [2:0] obit;
    logic [31:0] mem_addr;
  } sfcmd_frm_t;

  // Link state kept across frames
  typedef struct packed {
    logic std_m;
    logic std_s;
    logic [23:0] st_m;
    logic [23:0] st_s;
    logic tog;
    logic [7:0] opcode;
    logic [15:0] data;
    logic [6:0] nbits;
  } sfcmd_fr_t;

  // Link falling-edge output state
  typedef struct packed {
    logic dout;
    logic oe;
    logic [6:0] sh;
  } sfcmd_out_t;

  // System clock state
  typedef struct packed {
    logic cs_m;
    logic cs_s;
    logic tog_m;
    logic tog_s;
    logic tog_seen;
    logic vol_en;
    logic busy_nv;
    logic [9:0] timer;
    logic [7:0] pend1;
    logic [7:0] pend2;
    logic [7:0] pend3;
    logic [7:0] vsr1;
    logic [7:0] vsr2;
    logic [7:0] vsr3;
    logic [7:0] nsr1;
    logic [7:0] nsr2;
    logic [7:0] nsr3;
  } sfcmd_sys_t;
endpackage

// ==== hw/sfcmd_top.sv ====
// Serial flash status, address-mode and single-wire read command interpreter
`timescale 1ns/1ps
module sfcmd_top
  import sfcmd_pkg::*;
(
  input wire logic CLK, // System clock, 10 MHz
  input wire logic RST_B, // Power-on reset, async, active low
  input wire logic SCLK, // Serial clock from host
  input wire logic CS_B, // Chip select from host, active low
  input wire logic DI, // Serial data in
  output logic DO, // Serial data out
  output logic DO_OE, // Data out drive enable
  input wire logic STD_SPI_MODE, // High when in single-wire standard mode
  output logic [31:0] MEM_ADDR, // Array read address, SCLK domain
  input wire logic [7:0] MEM_RDATA, // Array data for MEM_ADDR
  input wire logic SOFT_RESET, // Reset instruction or pin, CLK pulse
  input wire logic EXT_BUSY, // Program or erase in progress, CLK level
  input wire logic OP_DONE, // Program or erase finished, CLK pulse
  output logic [7:0] STATUS1, // Status register 1
  output logic [7:0] STATUS2, // Status register 2
  output logic [7:0] STATUS3 // Status register 3
);

  sfcmd_frm_t frm;
  sfcmd_frm_t next_frm;
  sfcmd_fr_t fr;
  sfcmd_fr_t next_fr;
  sfcmd_out_t out;
  sfcmd_out_t next_out;
  sfcmd_sys_t sys;
  sfcmd_sys_t next_sys;
  logic link_rst_b;

  // Frame logic is held cleared whenever chip select is high
  assign link_rst_b = RST_B & ~CS_B;

  // Merge a written byte into a register, keeping read-only and set one-time bits
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wr,
                                       input logic [7:0] mask, input logic [7:0] otp);
    merge = (old & ~mask) | (wr & mask) | (old & otp);
  endfunction

  // Rising-edge link logic: opcode, address and data capture
  always_comb begin
    logic [7:0] op;
    logic four;
    logic busy;
    op = {frm.sh[6:0], DI};
    four = fr.st_s[16 + ADS_POS];
    busy = fr.st_s[BUSY_POS];
    next_frm = frm;
    next_fr = fr;
    next_fr.std_m = STD_SPI_MODE;
    next_fr.std_s = fr.std_m;
    next_fr.st_m = {sys.vsr3, sys.vsr2, sys.vsr1};
    next_fr.st_s = fr.st_m;
    next_frm.sh = op;
    if (frm.bits != 7'h7F) begin
      next_frm.bits = frm.bits + 7'h01;
    end
    next_fr.nbits = next_frm.bits;
    if (frm.bits == 7'h07) begin
      // Opcode complete: announce the frame and decide what follows
      next_fr.tog = ~fr.tog;
      next_fr.opcode = op;
      next_fr.data = 16'h0000;
      next_frm.addr = 32'h0000_0000;
      if ((op == OP_RDSR1) || (op == OP_RDSR2) || (op == OP_RDSR3)) begin
        next_frm.is_stat = 1'b1;
        next_frm.stream = 1'b1;
        next_frm.obit = 3'h0;
        next_frm.stat_sel = (op == OP_RDSR1) ? 2'h0 : ((op == OP_RDSR2) ? 2'h1 : 2'h2);
      end else if (((op == OP_READ) || (op == OP_READ4) || (op == OP_FAST))
                   && !busy && fr.std_s) begin
        // Busy or non-standard mode leaves the read unarmed
        next_frm.is_read = 1'b1;
        next_frm.addr_end = ((op == OP_READ4) || four) ? ADDR_END4 : ADDR_END3;
        next_frm.data_start = next_frm.addr_end + ((op == OP_FAST) ? DUMMY_BITS : 7'h00);
      end
    end else if (frm.bits < BITS_TWO) begin
      next_fr.data = {fr.data[14:0], DI};
    end
    // Address bits on rising edges; dummy bits fall past addr_end and are dropped
    if (frm.is_read && (frm.bits >= BITS_OP) && (frm.bits < frm.addr_end)) begin
      next_frm.addr = {frm.addr[30:0], DI};
    end
    if (frm.is_read && !frm.stream && (next_frm.bits == frm.data_start)) begin
      next_frm.stream = 1'b1;
      next_frm.obit = 3'h0;
      next_frm.mem_addr = next_frm.addr;
    end
    if (frm.stream) begin
      next_frm.obit = frm.obit + 3'h1;
      if ((frm.obit == 3'h7) && !frm.is_stat) begin
        next_frm.mem_addr = frm.mem_addr + 32'h0000_0001;
      end
    end
  end

  // Rising-edge registers cleared by chip select
  always_ff @(posedge SCLK or negedge link_rst_b) begin
    if (!link_rst_b) begin
      frm <= '0;
    end else begin
      frm <= next_frm;
    end
  end

  // Rising-edge registers that outlive the frame for the system side to read
  always_ff @(posedge SCLK or negedge RST_B) begin
    if (!RST_B) begin
      fr <= '0;
    end else begin
      fr <= next_fr;
    end
  end

  // Falling-edge output shifter; status repeats because obit wraps every eight clocks
  always_comb begin
    logic [7:0] byte_out;
    byte_out = MEM_RDATA;
    if (frm.is_stat) begin
      byte_out = fr.st_s[8 * frm.stat_sel +: 8];
    end
    next_out = out;
    next_out.oe = frm.stream;
    if (frm.stream) begin
      if (frm.obit == 3'h0) begin
        next_out.dout = byte_out[7];
        next_out.sh = byte_out[6:0];
      end else begin
        next_out.dout = out.sh[6];
        next_out.sh = {out.sh[5:0], 1'b0};
      end
    end
  end

  // Falling-edge registers
  always_ff @(negedge SCLK or negedge link_rst_b) begin
    if (!link_rst_b) begin
      out <= '0;
    end else begin
      out <= next_out;
    end
  end

  // System side: executes each finished frame once chip select has risen
  always_comb begin
    logic frame_end;
    logic [7:0] op;
    logic [6:0] nb;
    logic w1;
    logic w2;
    logic w3;
    logic [7:0] d1;
    logic [7:0] d2;
    logic we_set;
    logic busy_any;
    frame_end = sys.cs_s && (sys.tog_s != sys.tog_seen);
    op = fr.opcode;
    nb = fr.nbits;
    busy_any = sys.busy_nv | EXT_BUSY;
    w1 = 1'b0;
    w2 = 1'b0;
    w3 = 1'b0;
    d1 = fr.data[7:0];
    d2 = fr.data[7:0];
    we_set = 1'b0;
    next_sys = sys;
    next_sys.cs_m = CS_B;
    next_sys.cs_s = sys.cs_m;
    next_sys.tog_m = fr.tog;
    next_sys.tog_s = sys.tog_m;
    // Self-timed non-volatile write cycle
    if (sys.busy_nv) begin
      if (sys.timer == 10'h000) begin
        next_sys.busy_nv = 1'b0;
        next_sys.vsr1[WEL_POS] = 1'b0;
        next_sys.nsr1 = sys.pend1;
        next_sys.nsr2 = sys.pend2;
        next_sys.nsr3 = sys.pend3;
        next_sys.vsr1 = merge(next_sys.vsr1, sys.pend1, SR1_WMASK, 8'h00);
        next_sys.vsr2 = merge(sys.vsr2, sys.pend2, SR2_WMASK, 8'h00);
        next_sys.vsr3 = merge(sys.vsr3, sys.pend3, SR3_WMASK, 8'h00);
      end else begin
        next_sys.timer = sys.timer - 10'h001;
      end
    end
    // Program or erase completion also drops the latch
    if (OP_DONE) begin
      next_sys.vsr1[WEL_POS] = 1'b0;
    end
    if (frame_end) begin
      next_sys.tog_seen = sys.tog_s;
      if ((op == OP_WRSR1) && (nb == BITS_TWO)) begin
        w1 = 1'b1;
        w2 = 1'b1;
        d1 = fr.data[15:8];
      end else if ((op == OP_WRSR1) && (nb == BITS_ONE)) begin
        w1 = 1'b1;
      end else if ((op == OP_WRSR2) && (nb == BITS_ONE)) begin
        w2 = 1'b1;
      end else if ((op == OP_WRSR3) && (nb == BITS_ONE)) begin
        w3 = 1'b1;
      end
      if ((op != OP_VWREN) && (op != OP_RDSR1) && (op != OP_RDSR2) && (op != OP_RDSR3)) begin
        next_sys.vol_en = 1'b0;
      end
      if (op == OP_VWREN && nb == BITS_OP) begin
        next_sys.vol_en = 1'b1;
      end else if (op == OP_WREN && nb == BITS_OP && !busy_any) begin
        we_set = 1'b1;
      end else if (op == OP_WRDI && nb == BITS_OP) begin
        next_sys.vsr1[WEL_POS] = 1'b0;
      end else if (op == OP_EN4B && nb == BITS_OP && !busy_any) begin
        next_sys.vsr3[ADS_POS] = 1'b1;
      end else if (op == OP_EX4B && nb == BITS_OP && !busy_any) begin
        next_sys.vsr3[ADS_POS] = 1'b0;
      end else if ((w1 || w2 || w3) && sys.vol_en && !busy_any) begin
        // Volatile path: applied this cycle, busy never rises, latch untouched
        if (w1) begin
          next_sys.vsr1 = merge(sys.vsr1, d1, SR1_WMASK, 8'h00);
        end
        if (w2) begin
          next_sys.vsr2 = merge(sys.vsr2, d2, SR2_WMASK, SR2_OTP);
        end
        if (w3) begin
          next_sys.vsr3 = merge(sys.vsr3, d2, SR3_WMASK, 8'h00);
        end
      end else if ((w1 || w2 || w3) && sys.vsr1[WEL_POS] && !busy_any) begin
        // Non-volatile path: start the timed cycle with the merged values
        next_sys.busy_nv = 1'b1;
        next_sys.timer = TW_CYC - 10'h001;
        next_sys.pend1 = w1 ? merge(sys.nsr1, d1, SR1_WMASK, 8'h00) : sys.nsr1;
        next_sys.pend2 = w2 ? merge(sys.nsr2, d2, SR2_WMASK, SR2_OTP) : sys.nsr2;
        next_sys.pend3 = w3 ? merge(sys.nsr3, d2, SR3_WMASK, 8'h00) : sys.nsr3;
      end
      // A write with neither enable falls through and changes nothing
    end
    // Reset instruction or pin reloads volatile copies from the stored ones
    if (SOFT_RESET) begin
      next_sys.vsr1 = sys.nsr1 & SR1_WMASK;
      next_sys.vsr2 = sys.nsr2 & SR2_WMASK;
      next_sys.vsr3 = sys.nsr3 & SR3_WMASK;
      next_sys.vsr3[ADS_POS] = sys.nsr3[ADP_POS];
      next_sys.vol_en = 1'b0;
      next_sys.busy_nv = 1'b0;
    end
    // Setting the latch wins over any clear in the same cycle
    if (we_set) begin
      next_sys.vsr1[WEL_POS] = 1'b1;
    end
    next_sys.vsr1[BUSY_POS] = next_sys.busy_nv | EXT_BUSY;
  end

  // System registers; power-up loads defaults, volatile equals stored
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      sys <= '0;
      sys.cs_m <= 1'b1;
      sys.cs_s <= 1'b1;
      sys.nsr1 <= SR1_RST;
      sys.nsr2 <= SR2_RST;
      sys.nsr3 <= SR3_RST;
      sys.vsr1 <= SR1_RST & SR1_WMASK;
      sys.vsr2 <= SR2_RST & SR2_WMASK;
      sys.vsr3 <= SR3_RST & SR3_WMASK;
    end else begin
      sys <= next_sys;
    end
  end

  // Outputs straight from flip-flops
  assign DO = out.dout;
  assign DO_OE = out.oe;
  assign MEM_ADDR = frm.mem_addr;
  assign STATUS1 = sys.vsr1;
  assign STATUS2 = sys.vsr2;
  assign STATUS3 = sys.vsr3;

endmodule

// ==== sim/sfcmd_chk.sv ====
// Port assertions for the flash command block
`timescale 1ns/1ps
module sfcmd_chk
  import sfcmd_pkg::*;
(
  input logic CLK, // System clock
  input logic RST_B, // Reset, active low
  input logic SCLK, // Serial clock
  input logic CS_B, // Select, active low
  input logic DO_OE, // Data out enable
  input logic [31:0] MEM_ADDR, // Read address
  input logic SOFT_RESET, // Status reload
  input logic EXT_BUSY, // Program or erase
  input logic [7:0] STATUS1, // Status 1
  input logic [7:0] STATUS2, // Status 2
  input logic [7:0] STATUS3 // Status 3
);
  logic [6:0] nrise;
  logic [10:0] bcnt;
  // Rises since select, saturating so long reads never wrap
  always_ff @(posedge SCLK or posedge CS_B) begin
    if (CS_B) nrise <= 7'h00;
    else if (nrise != 7'h7F) nrise <= nrise + 7'h01;
  end
  // Length of the current busy run
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) bcnt <= 11'h000;
    else bcnt <= STATUS1[0] ? bcnt + 11'h001 : 11'h000;
  end
  property p_oe_idle;
    @(posedge CLK) disable iff (!RST_B) CS_B && $past(CS_B) |-> !DO_OE;
  endproperty
  a_oe_idle: assert property (p_oe_idle)
    else $error("data out enabled while deselected");
  property p_oe_late;
    @(posedge SCLK) disable iff (!RST_B) DO_OE |-> nrise >= 7'h08;
  endproperty
  a_oe_late: assert property (p_oe_late)
    else $error("data out before the opcode ended");
  property p_addr_step;
    @(posedge SCLK) disable iff (!RST_B) nrise != 7'h00 && $past(MEM_ADDR) != 32'h0
      && MEM_ADDR != $past(MEM_ADDR) |-> MEM_ADDR == $past(MEM_ADDR) + 32'h1;
  endproperty
  a_addr_step: assert property (p_addr_step)
    else $error("read address did not step by one");
  property p_busy_len;
    @(posedge CLK) disable iff (!RST_B) $fell(STATUS1[0]) && !EXT_BUSY && !$past(SOFT_RESET)
      |-> bcnt >= 11'(TW_CYC) - 11'h001 && bcnt <= 11'(TW_CYC) + 11'h001;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("write cycle length wrong");
  property p_busy_end;
    @(posedge CLK) disable iff (!RST_B) $fell(STATUS1[0]) && !EXT_BUSY |-> !STATUS1[1];
  endproperty
  a_busy_end: assert property (p_busy_end)
    else $error("latch kept after write cycle");
  property p_soft;
    @(posedge CLK) disable iff (!RST_B) SOFT_RESET |=> !STATUS1[1] && STATUS3[0] == STATUS3[1];
  endproperty
  a_soft: assert property (p_soft)
    else $error("reset did not reload status");
  property p_ro;
    @(posedge CLK) disable iff (!RST_B)
      {STATUS1[7], STATUS2[7], STATUS2[2], STATUS3[7], STATUS3[4:3]} == 6'h00;
  endproperty
  a_ro: assert property (p_ro)
    else $error("read-only status bit set");
  property p_otp;
    @(posedge CLK) disable iff (!RST_B)
      !$past(SOFT_RESET) |-> ($past(STATUS2) & ~STATUS2 & SR2_OTP) == 8'h00;
  endproperty
  a_otp: assert property (p_otp)
    else $error("lock bit returned to zero");
endmodule
bind sfcmd_top sfcmd_chk sfcmd_chk_i (.CLK(CLK), .RST_B(RST_B), .SCLK(SCLK), .CS_B(CS_B),
  .DO_OE(DO_OE), .MEM_ADDR(MEM_ADDR), .SOFT_RESET(SOFT_RESET), .EXT_BUSY(EXT_BUSY),
  .STATUS1(STATUS1), .STATUS2(STATUS2), .STATUS3(STATUS3));

// ==== sim/sfcmd_host.sv ====
// Host controller model for the serial port
`timescale 1ns/1ps
module sfcmd_host (
  output logic SCLK, // Serial clock
  output logic CS_B, // Select, active low
  output logic DI, // Data to device
  input wire logic DO, // Data from device
  input wire logic DO_OE // Device drive enable
);
  logic oe_any;
  // Idle: clock still, deselected
  initial begin
    SCLK = 1'b0;
    CS_B = 1'b1;
    DI = 1'b0;
    oe_any = 1'b0;
  end
  // One frame at 12 ns, every rise sampled into rx
  task automatic frame(input logic [63:0] tx, input int nb, input int nr,
                       output logic [63:0] rx);
    rx = '0;
    oe_any = 1'b0;
    CS_B = 1'b0;
    #6;
    for (int i = 0; i < nb + nr; i++) begin
      DI = (i < nb) ? tx[nb-1-i] : ~DI;
      #6 SCLK = 1'b1;
      rx = {rx[62:0], DO};
      oe_any = oe_any | DO_OE;
      #6 SCLK = 1'b0;
    end
    #6 CS_B = 1'b1;
    DI = ~DI; // Stale value never lingers
  endtask
endmodule

// ==== sim/test_serial_flash_status_and_read_cmds.sv ====
// Self-checking bench for the flash command block
`timescale 1ns/1ps
module test_serial_flash_status_and_read_cmds;
  import sfcmd_pkg::*;
  logic clk, rst_b, sclk, cs_b, di, dout, doe, smode, srst, xbusy, opd;
  logic [31:0] maddr;
  logic [7:0] mdata, st1, st2, st3;
  logic [63:0] rx;
  int fails;
  int compares;
  sfcmd_top sfcmd_top_i (.CLK(clk), .RST_B(rst_b), .SCLK(sclk), .CS_B(cs_b), .DI(di),
    .DO(dout), .DO_OE(doe), .STD_SPI_MODE(smode), .MEM_ADDR(maddr), .MEM_RDATA(mdata),
    .SOFT_RESET(srst), .EXT_BUSY(xbusy), .OP_DONE(opd), .STATUS1(st1), .STATUS2(st2),
    .STATUS3(st3));
  sfcmd_host sfcmd_host_i (.SCLK(sclk), .CS_B(cs_b), .DI(di), .DO(dout), .DO_OE(doe));
  // Array model, a pure function of address
  function automatic logic [7:0] mem(input logic [31:0] a);
    return a[7:0] ^ a[31:24] ^ 8'hA5;
  endfunction
  assign mdata = mem(maddr);
  // 10 MHz system clock
  always #50 clk = ~clk;
  // Compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  // Frame, then the idle gap the system side needs
  task automatic send(input logic [63:0] tx, input int nb, input int nr);
    sfcmd_host_i.frame(tx, nb, nr, rx);
    repeat (8) @(negedge clk);
  endtask
  // Three-byte read checked against the array model
  task automatic rd(input logic [7:0] op, input logic [31:0] a, input int ab, input int dm);
    send(((64'(op) << ab) | 64'(a)) << dm, 8 + ab + dm, 24);
    chk(rx[23:0], {mem(a), mem(a + 32'h1), mem(a + 32'h2)});
  endtask
  task automatic t_latch();
    send(64'h06, 8, 0);
    chk(st1, 8'h02);
    send(64'h05, 8, 16);
    chk(rx[15:0], 16'h0202);
    send(64'h04, 8, 0);
    chk(st1, 8'h00);
    send(64'h06, 8, 0);
    @(negedge clk) opd = 1'b1;
    @(negedge clk) opd = 1'b0;
    chk(st1, 8'h00);
  endtask
  task automatic t_vol();
    send(64'h50, 8, 0);
    send(64'h31FF, 16, 0);
    chk({st1, st2}, 16'h007B);
    send(64'h50, 8, 0);
    send(64'h3100, 16, 0);
    chk(st2, 8'h39);
    send(64'h3100, 16, 0);
    chk(st2, 8'h39);
    @(negedge clk) srst = 1'b1;
    @(negedge clk) srst = 1'b0;
    chk(st2, 8'h00);
  endtask
  task automatic t_nv();
    send(64'h0142, 16, 0);
    chk(st1, 8'h00);
    send(64'h06, 8, 0);
    send(64'h01FF42, 24, 0);
    chk(st1[0], 1'b1);
    // Busy and latch both set while the write cycle runs
    send(64'h05, 8, 8);
    chk(rx[7:0], 8'h03);
    send(64'h03123456, 32, 8);
    chk(sfcmd_host_i.oe_any, 1'b0);
    repeat (TW_CYC) @(negedge clk);
    chk({st1, st2}, 16'h7C42);
    send(64'h06, 8, 0);
    send(64'h0100, 16, 0);
    repeat (TW_CYC + 16) @(negedge clk);
    chk({st1, st2}, 16'h0042);
  endtask
  task automatic t_read();
    rd(OP_READ, 32'h001234FE, 24, 0);
    rd(OP_FAST, 32'h00ABCDEF, 24, 8);
    rd(OP_READ4, 32'h5A0000FF, 32, 0);
    send(64'hB7, 8, 0);
    chk(st3[0], 1'b1);
    rd(OP_READ, 32'hC30001FF, 32, 0);
    rd(OP_FAST, 32'h7E0010FE, 32, 8);
    send(64'hE9, 8, 0);
    chk(st3[0], 1'b0);
    rd(OP_READ4, 32'h01020304, 32, 0);
    @(negedge clk) smode = 1'b0;
    send(64'h03000010, 32, 24);
    chk(sfcmd_host_i.oe_any, 1'b0);
    @(negedge clk) smode = 1'b1;
  endtask
  // Verdict and end of run
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", fails, compares);
    if (fails == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    smode = 1'b1;
    srst = 1'b0;
    xbusy = 1'b0;
    opd = 1'b0;
    fails = 0;
    compares = 0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    chk({st1, st2, st3}, 24'h000000);
    t_latch();
    t_vol();
    t_nv();
    t_read();
    test_done();
  end
  // Watchdog, over twelve times the expected run of about 2400 cycles
  initial begin
    #3000000;
    fails++;
    test_done();
  end
endmodule
